// ===== hdl/pwmfr_pkg.sv
// Shared constants and types for the force, reload and clock select block
package pwmfr_pkg;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam int AXI_STRB_W = 4;
	localparam int BYTE_W = 8;
	localparam logic [1:0] WORD_LSB_ZERO = 2'h0;
	localparam logic [7:0] CONTROL_TWO_REGISTER_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Source encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FSRC_LOCAL = 3'b000,
		FSRC_MFORCE = 3'b001,
		FSRC_RELOAD = 3'b010,
		FSRC_MRELOAD = 3'b011,
		FSRC_SYNC = 3'b100,
		FSRC_MSYNC = 3'b101,
		FSRC_EXT = 3'b110,
		FSRC_RSVD = 3'b111
	} pwmfr_fsrc_t;

	typedef enum logic [1:0] {
		ISRC_LSYNC = 2'b00,
		ISRC_MRELOAD = 2'b01,
		ISRC_MSYNC = 2'b10,
		ISRC_EXT = 2'b11
	} pwmfr_isrc_t;

	typedef enum logic [1:0] {
		CSRC_BUS = 2'b00,
		CSRC_EXT = 2'b01,
		CSRC_AUX = 2'b10,
		CSRC_RSVD = 2'b11
	} pwmfr_csrc_t;

	typedef enum logic {
		RSRC_LOCAL = 1'b0,
		RSRC_MASTER = 1'b1
	} pwmfr_rsrc_t;

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] upper;
		logic aux_init;
		pwmfr_isrc_t init_sel;
		logic force_init_enable;
		logic force_trigger;
		pwmfr_fsrc_t force_sel;
		pwmfr_rsrc_t reload_sel;
		pwmfr_csrc_t clk_sel;
	} pwmfr_control_two_register_t;

	typedef struct packed {
		logic [12:0] unused;
		logic reload_seen;
		logic init_seen;
		logic force_seen;
	} pwmfr_status_t;

	localparam int REG_W = 16;
	localparam int REG_BYTES = 2;
	localparam logic [15:0] CONTROL_TWO_REGISTER_WMASK = 16'h07bf;
	localparam logic [15:0] CONTROL_TWO_REGISTER_RESET = 16'h0000;
	localparam logic [15:0] STATUS_W1C_MASK = 16'h0007;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam int MASTER_SUBMODULE = 0;

endpackage : pwmfr_pkg

// ===== hdl/pwmfr_sel_if.sv
// Bundle between the register side and the source selector
`timescale 1ns/1ps
interface pwmfr_sel_if;
	pwmfr_pkg::pwmfr_control_two_register_t ctrl;
	logic sw_force;
	logic local_reload;
	logic local_load_okay_bit;
	logic local_sync;
	logic master_force;
	logic master_reload;
	logic master_sync;
	logic external_force_input;
	logic external_sync_input;
	logic external_clock_input;
	logic aux_clk;
	logic force_trig;
	logic init_trig;
	logic forced_init;
	logic reload_trig;
	logic cnt_tick;

	modport ctl (
		output ctrl, sw_force, local_reload, local_load_okay_bit, local_sync, master_force, master_reload,
		output master_sync, external_force_input, external_sync_input, external_clock_input, aux_clk,
		input force_trig, init_trig, forced_init, reload_trig, cnt_tick
	);
	modport sel (
		input ctrl, sw_force, local_reload, local_load_okay_bit, local_sync, master_force, master_reload,
		input master_sync, external_force_input, external_sync_input, external_clock_input, aux_clk,
		output force_trig, init_trig, forced_init, reload_trig, cnt_tick
	);
endinterface : pwmfr_sel_if

// ===== hdl/pwmfr_select.sv
// Source multiplexers for force, init, reload and counter tick
`timescale 1ns/1ps
module pwmfr_select #(
	parameter int SUB_INDEX = 3
) (
	pwmfr_sel_if.sel sif
);
	// Submodule 0 has no master above it, so master choices read as low
	localparam bit IS_MASTER = (SUB_INDEX == pwmfr_pkg::MASTER_SUBMODULE);

	logic init_src;

	always_comb begin
		sif.force_trig = 1'b0;
		unique case (sif.ctrl.force_sel)
			pwmfr_pkg::FSRC_LOCAL: sif.force_trig = sif.sw_force;
			pwmfr_pkg::FSRC_MFORCE: sif.force_trig = !IS_MASTER && sif.master_force;
			pwmfr_pkg::FSRC_RELOAD: sif.force_trig = sif.local_reload;
			pwmfr_pkg::FSRC_MRELOAD: sif.force_trig = !IS_MASTER && sif.master_reload;
			pwmfr_pkg::FSRC_SYNC: sif.force_trig = sif.local_sync;
			pwmfr_pkg::FSRC_MSYNC: sif.force_trig = !IS_MASTER && sif.master_sync;
			pwmfr_pkg::FSRC_EXT: sif.force_trig = sif.external_force_input;
			pwmfr_pkg::FSRC_RSVD: sif.force_trig = 1'b0;
		endcase

		init_src = 1'b0;
		unique case (sif.ctrl.init_sel)
			pwmfr_pkg::ISRC_LSYNC: init_src = sif.local_sync;
			pwmfr_pkg::ISRC_MRELOAD: init_src = !IS_MASTER && sif.master_reload;
			pwmfr_pkg::ISRC_MSYNC: init_src = !IS_MASTER && sif.master_sync;
			pwmfr_pkg::ISRC_EXT: init_src = sif.external_sync_input;
		endcase
		// Force-driven init bypasses the init source choice
		sif.forced_init = sif.ctrl.force_init_enable && sif.force_trig;
		sif.init_trig = init_src || sif.forced_init;

		sif.reload_trig = 1'b0;
		unique case (sif.ctrl.reload_sel)
			pwmfr_pkg::RSRC_LOCAL: sif.reload_trig = sif.local_reload && sif.local_load_okay_bit;
			pwmfr_pkg::RSRC_MASTER: sif.reload_trig = !IS_MASTER && sif.master_reload;
		endcase

		sif.cnt_tick = 1'b0;
		unique case (sif.ctrl.clk_sel)
			pwmfr_pkg::CSRC_BUS: sif.cnt_tick = 1'b1;
			pwmfr_pkg::CSRC_EXT: sif.cnt_tick = sif.external_clock_input;
			pwmfr_pkg::CSRC_AUX: sif.cnt_tick = !IS_MASTER && sif.aux_clk;
			pwmfr_pkg::CSRC_RSVD: sif.cnt_tick = 1'b0;
		endcase
	end
endmodule : pwmfr_select

// ===== hdl/pwmfr_top.sv
// Force trigger, init, reload and clock source control with AXI4-Lite registers
//
// Behaviour
// - Force event loads counter only while force-init enable is set.
// - Source 000: writing 1 to force trigger bit makes a force event.
// - Force event drives outputs A and B to externally chosen force values.
// - Forced init loads counter with initial count register contents.
// - Source 001 uses submodule 0 master force as trigger.
// - Source 010 uses local reload, 100 uses local sync.
// - Source 101 uses submodule 0 master sync.
// - Source 110 uses external force input; 111 reserved, gives nothing.
// - In submodule 0, master force sources hold force output low.
// - Reload select 0 picks local reload, 1 picks master reload.
// - With master reload, local load-okay is ignored; software uses submodule 0's.
// - Submodule 0 selecting master reload keeps reload low.
// - Clock select: 00 bus clock, 01 external clock, 10 aux clock, 11 reserved.
// - Submodule 0 selecting aux clock holds its counter clock low.
// - Init select: 00 local sync, 01 master reload, 10 master sync, 11 external sync.
// - Forced init drives auxiliary output to its configured initial value.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pwmfr_top #(
	parameter int SUB_INDEX = 3
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [pwmfr_pkg::AXI_ADDR_W-1:0] AWADDR_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	input wire logic [pwmfr_pkg::AXI_DATA_W-1:0] WDATA_I,
	input wire logic [pwmfr_pkg::AXI_STRB_W-1:0] WSTRB_I,
	output logic BVALID_O,
	input wire logic BREADY_I,
	output logic [1:0] BRESP_O,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	input wire logic [pwmfr_pkg::AXI_ADDR_W-1:0] ARADDR_I,
	output logic RVALID_O,
	input wire logic RREADY_I,
	output logic [pwmfr_pkg::AXI_DATA_W-1:0] RDATA_O,
	output logic [1:0] RRESP_O,
	input wire logic LOCAL_RELOAD_I,
	input wire logic LOAD_OKAY_BIT_I,
	input wire logic LOCAL_SYNC_I,
	input wire logic MASTER_FORCE_I,
	input wire logic MASTER_RELOAD_I,
	input wire logic MASTER_SYNC_I,
	input wire logic EXTERNAL_FORCE_INPUT_I,
	input wire logic EXTERNAL_SYNC_INPUT_I,
	input wire logic EXTERNAL_CLOCK_INPUT_I,
	input wire logic AUX_CLK_I,
	input wire logic OUTPUT_A_FORCE_SOURCE_I,
	input wire logic OUTPUT_B_FORCE_SOURCE_I,
	output logic FORCE_OUT_O,
	output logic INIT_LOAD_O,
	output logic RELOAD_O,
	output logic CNT_TICK_O,
	output logic OUTPUT_A_O,
	output logic OUTPUT_B_O,
	output logic AUXILIARY_OUTPUT_O
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_got;
		logic [pwmfr_pkg::AXI_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [pwmfr_pkg::AXI_DATA_W-1:0] wdata;
		logic [pwmfr_pkg::AXI_STRB_W-1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [pwmfr_pkg::AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
		pwmfr_pkg::pwmfr_control_two_register_t ctrl;
		pwmfr_pkg::pwmfr_status_t status;
		logic sw_force;
		logic force_out;
		logic init_load;
		logic reload;
		logic cnt_tick;
		logic out_a;
		logic out_b;
		logic aux_out;
	} pwmfr_top_state_t;

	pwmfr_top_state_t s;
	pwmfr_top_state_t next_s;
	logic rst_meta;
	logic rst_n;
	pwmfr_pkg::pwmfr_control_two_register_t rd_ctl;

	pwmfr_sel_if sif ();

	pwmfr_select #(
		.SUB_INDEX(SUB_INDEX)
	) u_select (
		.sif(sif.sel)
	);

	assign sif.ctrl = s.ctrl;
	assign sif.sw_force = s.sw_force;
	assign sif.local_reload = LOCAL_RELOAD_I;
	assign sif.local_load_okay_bit = LOAD_OKAY_BIT_I;
	assign sif.local_sync = LOCAL_SYNC_I;
	assign sif.master_force = MASTER_FORCE_I;
	assign sif.master_reload = MASTER_RELOAD_I;
	assign sif.master_sync = MASTER_SYNC_I;
	assign sif.external_force_input = EXTERNAL_FORCE_INPUT_I;
	assign sif.external_sync_input = EXTERNAL_SYNC_INPUT_I;
	assign sif.external_clock_input = EXTERNAL_CLOCK_INPUT_I;
	assign sif.aux_clk = AUX_CLK_I;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	// Asserted at once, released only after two clean edges
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [pwmfr_pkg::REG_W-1:0] word;
		logic [pwmfr_pkg::AXI_ADDR_W-1:0] waddr;
		logic [pwmfr_pkg::AXI_ADDR_W-1:0] raddr;
		logic [pwmfr_pkg::REG_W-1:0] clr;
		pwmfr_pkg::pwmfr_control_two_register_t wctl;
		word = '0;
		waddr = '0;
		raddr = '0;
		clr = '0;
		wctl = '0;
		next_s = s;
		next_s.sw_force = 1'b0;

		if (AWVALID_I && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = AWADDR_I;
		end
		if (WVALID_I && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = WDATA_I;
			next_s.wstrb = WSTRB_I;
		end
		if (s.bvalid && BREADY_I) begin
			next_s.bvalid = 1'b0;
		end

		// Write commits once both halves are held and no answer is pending
		if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = pwmfr_pkg::RESP_OKAY;
			waddr = {next_s.aw_addr[pwmfr_pkg::AXI_ADDR_W-1:2], pwmfr_pkg::WORD_LSB_ZERO};
			if (waddr == pwmfr_pkg::CONTROL_TWO_REGISTER_OFF) begin
				word = s.ctrl;
				for (int b = 0; b < pwmfr_pkg::REG_BYTES; b++) begin
					if (next_s.wstrb[b]) begin
						word[b*pwmfr_pkg::BYTE_W +: pwmfr_pkg::BYTE_W] =
							next_s.wdata[b*pwmfr_pkg::BYTE_W +: pwmfr_pkg::BYTE_W];
					end
				end
				// Trigger bit is not stored, only strobed against the new select value
				wctl = word;
				next_s.sw_force = wctl.force_trigger && next_s.wstrb[0];
				next_s.ctrl = pwmfr_pkg::pwmfr_control_two_register_t'(word & pwmfr_pkg::CONTROL_TWO_REGISTER_WMASK);
			end else if (waddr == pwmfr_pkg::STATUS_OFF) begin
				for (int b = 0; b < pwmfr_pkg::REG_BYTES; b++) begin
					if (next_s.wstrb[b]) begin
						clr[b*pwmfr_pkg::BYTE_W +: pwmfr_pkg::BYTE_W] =
							next_s.wdata[b*pwmfr_pkg::BYTE_W +: pwmfr_pkg::BYTE_W];
					end
				end
				next_s.status = pwmfr_pkg::pwmfr_status_t'(s.status & ~(clr & pwmfr_pkg::STATUS_W1C_MASK));
			end else begin
				next_s.bresp = pwmfr_pkg::RESP_SLVERR;
			end
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;

		if (s.rvalid && RREADY_I) begin
			next_s.rvalid = 1'b0;
		end
		if (ARVALID_I && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = pwmfr_pkg::RESP_OKAY;
			next_s.rdata = '0;
			raddr = {ARADDR_I[pwmfr_pkg::AXI_ADDR_W-1:2], pwmfr_pkg::WORD_LSB_ZERO};
			if (raddr == pwmfr_pkg::CONTROL_TWO_REGISTER_OFF) begin
				next_s.rdata[pwmfr_pkg::REG_W-1:0] = s.ctrl;
			end else if (raddr == pwmfr_pkg::STATUS_OFF) begin
				next_s.rdata[pwmfr_pkg::REG_W-1:0] = s.status;
			end else begin
				next_s.rresp = pwmfr_pkg::RESP_SLVERR;
			end
		end
		next_s.arready = !next_s.rvalid;

		// Set beats clear in the same cycle
		if (sif.force_trig) next_s.status.force_seen = 1'b1;
		if (sif.init_trig) next_s.status.init_seen = 1'b1;
		if (sif.reload_trig) next_s.status.reload_seen = 1'b1;

		next_s.force_out = sif.force_trig;
		next_s.init_load = sif.init_trig;
		next_s.reload = sif.reload_trig;
		next_s.cnt_tick = sif.cnt_tick;
		if (sif.force_trig) begin
			next_s.out_a = OUTPUT_A_FORCE_SOURCE_I;
			next_s.out_b = OUTPUT_B_FORCE_SOURCE_I;
		end
		if (sif.forced_init) begin
			next_s.aux_out = s.ctrl.aux_init;
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.ctrl <= pwmfr_pkg::pwmfr_control_two_register_t'(pwmfr_pkg::CONTROL_TWO_REGISTER_RESET);
			s.status <= pwmfr_pkg::pwmfr_status_t'(pwmfr_pkg::STATUS_RESET);
		end else begin
			s <= next_s;
		end
	end

	assign AWREADY_O = s.awready;
	assign WREADY_O = s.wready;
	assign BVALID_O = s.bvalid;
	assign BRESP_O = s.bresp;
	assign ARREADY_O = s.arready;
	assign RVALID_O = s.rvalid;
	assign RDATA_O = s.rdata;
	assign RRESP_O = s.rresp;
	assign FORCE_OUT_O = s.force_out;
	assign INIT_LOAD_O = s.init_load;
	assign RELOAD_O = s.reload;
	assign CNT_TICK_O = s.cnt_tick;
	assign OUTPUT_A_O = s.out_a;
	assign OUTPUT_B_O = s.out_b;
	assign AUXILIARY_OUTPUT_O = s.aux_out;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!rst_n);

	// Read data viewed through the control layout to find the trigger bit
	assign rd_ctl = RDATA_O[pwmfr_pkg::REG_W-1:0];

	sw_force_a: assert property (s.sw_force && s.ctrl.force_sel == pwmfr_pkg::FSRC_LOCAL |=> FORCE_OUT_O)
		else $error("software force did not reach force output");
	external_force_input_a: assert property ((s.ctrl.force_sel == pwmfr_pkg::FSRC_EXT) && EXTERNAL_FORCE_INPUT_I
		|=> FORCE_OUT_O)
		else $error("external force not passed");
	rsvd_force_a: assert property (s.ctrl.force_sel == pwmfr_pkg::FSRC_RSVD |=> !FORCE_OUT_O)
		else $error("reserved force source fired");
	local_reload_frc_a: assert property ((s.ctrl.force_sel == pwmfr_pkg::FSRC_RELOAD) && LOCAL_RELOAD_I
		|=> FORCE_OUT_O)
		else $error("local reload did not force");
	master_sync_frc_a: assert property ((s.ctrl.force_sel == pwmfr_pkg::FSRC_MSYNC) && MASTER_SYNC_I
		|=> FORCE_OUT_O == (SUB_INDEX != pwmfr_pkg::MASTER_SUBMODULE))
		else $error("master sync force wrong");
	frc_init_a: assert property (FORCE_OUT_O && $past(s.ctrl.force_init_enable) |-> INIT_LOAD_O)
		else $error("enabled force did not load counter");
	no_frc_init_a: assert property (sif.force_trig && !s.ctrl.force_init_enable && !sif.init_trig
		|=> !INIT_LOAD_O)
		else $error("force loaded counter while disabled");
	external_sync_input_init_a: assert property ((s.ctrl.init_sel == pwmfr_pkg::ISRC_EXT) && EXTERNAL_SYNC_INPUT_I
		|=> INIT_LOAD_O)
		else $error("external sync did not init");
	out_force_a: assert property (sif.force_trig
		|=> OUTPUT_A_O == $past(OUTPUT_A_FORCE_SOURCE_I) && OUTPUT_B_O == $past(OUTPUT_B_FORCE_SOURCE_I))
		else $error("outputs not forced to chosen values");
	aux_init_a: assert property (sif.forced_init |=> AUXILIARY_OUTPUT_O == $past(s.ctrl.aux_init))
		else $error("aux output not set on forced init");
	master_reload_a: assert property (s.ctrl.reload_sel == pwmfr_pkg::RSRC_MASTER
		|=> RELOAD_O == ($past(MASTER_RELOAD_I) && SUB_INDEX != pwmfr_pkg::MASTER_SUBMODULE))
		else $error("master reload select wrong");
	bus_tick_a: assert property ((s.ctrl.clk_sel == pwmfr_pkg::CSRC_BUS) [*2] |=> CNT_TICK_O)
		else $error("bus clock tick missing");
	aux_tick_a: assert property (s.ctrl.clk_sel == pwmfr_pkg::CSRC_AUX
		|=> CNT_TICK_O == ($past(AUX_CLK_I) && SUB_INDEX != pwmfr_pkg::MASTER_SUBMODULE))
		else $error("aux clock selection wrong");
	trig_read_a: assert property (RVALID_O |-> !rd_ctl.force_trigger)
		else $error("force trigger bit read back set");

	sw_force_c: cover property (s.sw_force ##1 FORCE_OUT_O && INIT_LOAD_O);
	external_force_input_c: cover property (s.ctrl.force_sel == pwmfr_pkg::FSRC_EXT ##1 FORCE_OUT_O);
	master_reload_c: cover property (s.ctrl.reload_sel == pwmfr_pkg::RSRC_MASTER ##1 RELOAD_O);
	ext_tick_c: cover property (s.ctrl.clk_sel == pwmfr_pkg::CSRC_EXT ##1 CNT_TICK_O);
endmodule : pwmfr_top

// ===== verification/pwmfr_partner.sv
// Far-side model: submodule 0 master events and external event and tick inputs
`timescale 1ns/1ps
module pwmfr_partner (
	input wire logic clk_i,
	input wire logic [8:0] fire_i,
	output logic [8:0] line_o
);
	// Lines: 0 local reload, 1 local sync, 2 master force, 3 master reload, 4 master sync,
	// 5 external_force_input, 6 external_sync_input, 7 ext tick, 8 aux tick
	// Events are one-cycle pulses, low between events since every line is active high
	always_ff @(posedge clk_i) begin
		line_o <= fire_i;
	end
endmodule : pwmfr_partner

// ===== verification/testbench.sv
// Self-checking bench for the force, reload and clock select block
`timescale 1ns/1ps
module testbench;
	logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic load_okay_bit, src_a, src_b, force_out, init_load, reload, tick, out_a, out_b, aux_out;
	logic [8:0] fire, line;
	pwmfr_pkg::pwmfr_control_two_register_t c;
	int fail_count, cmp_count, cycles;
	int cnt[4], s[4], d[4];
	int fcode[7] = '{1, 2, 3, 4, 5, 6, 7};
	int fline[7] = '{2, 0, 3, 1, 4, 5, 5};
	int fexp[7] = '{1, 1, 1, 1, 1, 1, 0};
	int iline[4] = '{1, 3, 4, 6};
	int cline[4] = '{9, 7, 8, 8};
	int cexp[4] = '{5, 1, 1, 0};

	pwmfr_partner far_side (.clk_i(clk), .fire_i(fire), .line_o(line));

	pwmfr_top dut (.CLK_I(clk), .RESETN_I(resetn), .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr),
		.WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb), .BVALID_O(bvalid),
		.BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr),
		.RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp), .LOCAL_RELOAD_I(line[0]),
		.LOAD_OKAY_BIT_I(load_okay_bit), .LOCAL_SYNC_I(line[1]), .MASTER_FORCE_I(line[2]), .MASTER_RELOAD_I(line[3]),
		.MASTER_SYNC_I(line[4]), .EXTERNAL_FORCE_INPUT_I(line[5]), .EXTERNAL_SYNC_INPUT_I(line[6]),
		.EXTERNAL_CLOCK_INPUT_I(line[7]), .AUX_CLK_I(line[8]), .OUTPUT_A_FORCE_SOURCE_I(src_a),
		.OUTPUT_B_FORCE_SOURCE_I(src_b), .FORCE_OUT_O(force_out), .INIT_LOAD_O(init_load), .RELOAD_O(reload),
		.CNT_TICK_O(tick), .OUTPUT_A_O(out_a), .OUTPUT_B_O(out_b), .AUXILIARY_OUTPUT_O(aux_out));

	// ----------------------------------------------------------------
	// Clock, pulse counters and timeout
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Counted on the falling edge so registered outputs have settled
	always @(negedge clk) begin
		if (force_out === 1'b1) cnt[0]++;
		if (init_load === 1'b1) cnt[1]++;
		if (reload === 1'b1) cnt[2]++;
		if (tick === 1'b1) cnt[3]++;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk_val

	task automatic chk_cnt(input int got, input int exp, input string msg);
		cmp_count++;
		if (got != exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s count %0d expected %0d", $time, msg, got, exp);
		end
	endtask : chk_cnt

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rsp);
		bit aw_done;
		bit w_done;
		@(posedge clk);
		awaddr <= a;
		wdata <= dv;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rsp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		dv = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic diff();
		repeat (4) @(posedge clk);
		foreach (d[k]) d[k] = cnt[k] - s[k];
	endtask : diff

	// Pulse counts cover the whole write, so a software force is caught wherever it lands
	task automatic set_ctrl(input pwmfr_pkg::pwmfr_control_two_register_t cv);
		s = cnt;
		axi_wr(pwmfr_pkg::CONTROL_TWO_REGISTER_OFF, {16'h0000, cv}, r);
		chk_val({30'h0, r}, {30'h0, pwmfr_pkg::RESP_OKAY}, "ctrl resp");
		diff();
	endtask : set_ctrl

	task automatic pulse(input int idx);
		s = cnt;
		fire <= (idx < 9) ? (9'h001 << idx) : 9'h000;
		@(posedge clk);
		fire <= 9'h000;
		diff();
	endtask : pulse

	task automatic stop_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready, load_okay_bit, src_a, src_b} = '0;
		{awaddr, araddr, wdata, wstrb, fire} = '0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		axi_rd(pwmfr_pkg::CONTROL_TWO_REGISTER_OFF, v, r);
		chk_val(v, {16'h0000, pwmfr_pkg::CONTROL_TWO_REGISTER_RESET}, "ctrl reset");
		axi_rd(8'h08, v, r);
		chk_val({30'h0, r}, {30'h0, pwmfr_pkg::RESP_SLVERR}, "unmapped read");
		axi_wr(8'h08, 32'h0000ffff, r);
		chk_val({30'h0, r}, {30'h0, pwmfr_pkg::RESP_SLVERR}, "unmapped write");
		axi_wr(pwmfr_pkg::CONTROL_TWO_REGISTER_OFF, 32'h0000ffff, r);
		axi_rd(pwmfr_pkg::CONTROL_TWO_REGISTER_OFF, v, r);
		chk_val(v, {16'h0000, pwmfr_pkg::CONTROL_TWO_REGISTER_WMASK}, "ctrl readback");
		$display("Test registers done");
		load_okay_bit <= 1'b1;
		src_b <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			c = '0;
			c.force_sel = pwmfr_pkg::pwmfr_fsrc_t'(fcode[i]);
			set_ctrl(c);
			pulse(fline[i]);
			chk_cnt(d[0], fexp[i], "force source");
		end
		chk_val({31'h0, out_a}, 32'h0, "output a");
		chk_val({31'h0, out_b}, 32'h1, "output b");
		$display("Test force sources done");
		src_a <= 1'b1;
		src_b <= 1'b0;
		c = '0;
		c.force_trigger = 1'b1;
		c.force_init_enable = 1'b1;
		c.aux_init = 1'b1;
		set_ctrl(c);
		chk_cnt(d[0], 1, "soft force");
		chk_cnt(d[1], 1, "forced init");
		chk_val({30'h0, out_a, out_b}, 32'h2, "outputs a b");
		chk_val({31'h0, aux_out}, 32'h1, "aux output");
		c.force_init_enable = 1'b0;
		c.aux_init = 1'b0;
		set_ctrl(c);
		chk_cnt(d[0], 1, "soft force");
		chk_cnt(d[1], 0, "init disabled");
		chk_val({31'h0, aux_out}, 32'h1, "aux kept");
		c.force_sel = pwmfr_pkg::FSRC_EXT;
		set_ctrl(c);
		chk_cnt(d[0], 0, "soft force other source");
		$display("Test software force done");
		c = '0;
		set_ctrl(c);
		pulse(0);
		chk_cnt(d[2], 1, "local reload");
		load_okay_bit <= 1'b0;
		pulse(0);
		chk_cnt(d[2], 0, "reload no load okay");
		c.reload_sel = pwmfr_pkg::RSRC_MASTER;
		set_ctrl(c);
		pulse(3);
		chk_cnt(d[2], 1, "master reload");
		load_okay_bit <= 1'b1;
		pulse(0);
		chk_cnt(d[2], 0, "local ignored");
		$display("Test reload done");
		for (int i = 0; i < 4; i++) begin
			c = '0;
			c.init_sel = pwmfr_pkg::pwmfr_isrc_t'(i);
			set_ctrl(c);
			pulse(iline[i]);
			chk_cnt(d[1], 1, "init source");
		end
		for (int i = 0; i < 4; i++) begin
			c = '0;
			c.clk_sel = pwmfr_pkg::pwmfr_csrc_t'(i);
			set_ctrl(c);
			pulse(cline[i]);
			chk_cnt(d[3], cexp[i], "clock source");
		end
		$display("Test init and clock select done");
		axi_rd(pwmfr_pkg::STATUS_OFF, v, r);
		chk_val(v, {16'h0000, pwmfr_pkg::STATUS_W1C_MASK}, "status sticky");
		axi_wr(pwmfr_pkg::STATUS_OFF, {16'h0000, pwmfr_pkg::STATUS_W1C_MASK}, r);
		chk_val({30'h0, r}, {30'h0, pwmfr_pkg::RESP_OKAY}, "status clear resp");
		axi_rd(pwmfr_pkg::STATUS_OFF, v, r);
		chk_val(v, {16'h0000, pwmfr_pkg::STATUS_RESET}, "status cleared");
		$display("Test status done");
		stop_test();
	end
endmodule : testbench
